// >>> verif/frame_partner.sv
// Sample source and stalling receiver facing the volume stage
`timescale 1ns/1ps
module frame_partner #(
   parameter int DATA_W = 24
) (
   input  wire logic              i_core_clk,
   input  wire logic              i_in_ready,
   input  wire logic              i_out_valid,
   input  wire logic [DATA_W-1:0] i_first,
   input  wire logic [DATA_W-1:0] i_second,
   input  wire logic              i_stall,
   output logic                   o_valid,
   output logic [DATA_W-1:0]      o_first,
   output logic [DATA_W-1:0]      o_second,
   output logic                   o_ready
);
   logic [2*DATA_W-1:0] got_q[$];
   assign o_ready = !i_stall;
   initial begin
      o_valid  = 1'b0;
      o_first  = '0;
      o_second = '0;
   end
   always @(posedge i_core_clk) begin
      if (i_out_valid && o_ready) got_q.push_back({i_first, i_second});
   end
   // Ready only moves on rising edges, so its low-phase value is the one taken
   task automatic send(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
      @(negedge i_core_clk);
      o_valid  = 1'b1;
      o_first  = a;
      o_second = b;
      while (!i_in_ready) @(negedge i_core_clk);
      @(negedge i_core_clk);
      o_valid  = 1'b0;
      o_first  = ~a;
      o_second = ~b;
   endtask
endmodule

// >>> verif/stereo_digital_volume_mute_checker.sv
// Port-level assertions of the volume stage
`timescale 1ns/1ps
module stereo_digital_volume_mute_checker #(
   parameter int DATA_W = 24
) (
   input wire logic              i_core_clk,
   input wire logic              i_srst,
   input wire logic              i_reg_wr,
   input wire logic              i_reg_rd,
   input wire logic [7:0]        i_reg_addr,
   input wire logic [7:0]        i_reg_wdata,
   input wire logic [7:0]        o_reg_rdata,
   input wire logic              i_in_valid,
   input wire logic              o_in_ready,
   input wire logic              o_out_valid,
   input wire logic              i_out_ready,
   input wire logic [DATA_W-1:0] o_first_channel_output,
   input wire logic [DATA_W-1:0] o_second_channel_output,
   input wire logic              o_both_silenced_indicator
);
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_srst);
   logic [7:0]      ctl;
   logic [7:0]      lva;
   logic [7:0]      lvb;
   wire logic [7:0] effb   = ctl[7] ? lva : lvb;
   wire logic       both   = (lva[7] || lva[6:0] >= 7'h5F) && (effb[7] || effb[6:0] >= 7'h5F);
   wire logic       mapped = i_reg_addr inside {8'h02, 8'h03, 8'h04};
   wire logic [7:0] rsel   = (i_reg_addr == 8'h02) ? ctl : (i_reg_addr[0] ? lva : lvb);
   wire logic       take   = i_in_valid && o_in_ready;
   // Shadow registers, so reads are judged against the writes seen
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         ctl <= 8'h49;
         lva <= 8'h00;
         lvb <= 8'h00;
      end else if (i_reg_wr) begin
         if (i_reg_addr == 8'h02) ctl <= i_reg_wdata;
         if (i_reg_addr == 8'h03) lva <= i_reg_wdata;
         if (i_reg_addr == 8'h04) lvb <= i_reg_wdata;
      end
   end
   sequence s_take;
      take;
   endsequence
   sequence s_busy;
      !o_in_ready [*8];
   endsequence
   a_reset_state: assert property (
      $fell(i_srst) |-> o_in_ready && !o_out_valid && o_reg_rdata == 8'h00 && !o_both_silenced_indicator)
      else $error("bad state after reset");
   a_read_back: assert property (i_reg_rd && mapped |=> o_reg_rdata == $past(rsel))
      else $error("register read wrong");
   a_unmapped_zero: assert property (i_reg_rd && !mapped |=> o_reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
      else $error("read data moved");
   a_busy_after_take: assert property (s_take |=> s_busy)
      else $error("frame taken while busy");
   a_frame_latency: assert property (take && !o_out_valid |-> ##14 o_out_valid)
      else $error("frame late");
   a_valid_from_take: assert property ($rose(o_out_valid) |-> $past(take, 14))
      else $error("output without frame");
   a_out_holds: assert property (o_out_valid && !i_out_ready |=> o_out_valid &&
      $stable(o_first_channel_output) && $stable(o_second_channel_output))
      else $error("output dropped while stalled");
   a_silence_cause: assert property (o_both_silenced_indicator |-> both || $past(both))
      else $error("indicator without silence");
endmodule
bind stereo_digital_volume_mute stereo_digital_volume_mute_checker #(.DATA_W(DATA_W)) chk (
   .i_core_clk, .i_srst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_in_valid,
   .o_in_ready, .o_out_valid, .i_out_ready, .o_first_channel_output, .o_second_channel_output,
   .o_both_silenced_indicator);

// >>> verif/test_stereo_digital_volume_mute.sv
// Self-checking bench of the volume stage
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin \
   checks_done++; \
   if ((got) !== (exp)) begin \
      fail_count++; \
      $display("mismatch %s expected %h seen %h", nm, exp, got); \
   end \
end
module test_stereo_digital_volume_mute;
   localparam logic [23:0] S   = 24'h100000;
   localparam logic [23:0] NEG = 24'hF00000;
   logic             i_core_clk  = 1'b0;
   logic             i_srst      = 1'b1;
   logic             i_reg_wr    = 1'b0;
   logic             i_reg_rd    = 1'b0;
   logic [7:0]       i_reg_addr  = 8'h00;
   logic [7:0]       i_reg_wdata = 8'h00;
   logic             stall       = 1'b0;
   logic [47:0]      g;
   int               fail_count  = 0;
   int               checks_done = 0;
   int               cycles      = 0;
   wire logic [7:0]  o_reg_rdata;
   wire logic        i_in_valid, o_in_ready, o_out_valid, i_out_ready, o_both_silenced_indicator;
   wire logic [23:0] i_first_sample, i_second_sample, o_first_channel_output, o_second_channel_output;
   stereo_digital_volume_mute dut (.i_core_clk, .i_srst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
      .o_reg_rdata, .i_in_valid, .o_in_ready, .i_first_sample, .i_second_sample, .o_out_valid, .i_out_ready,
      .o_first_channel_output, .o_second_channel_output, .o_both_silenced_indicator);
   frame_partner pm (.i_core_clk, .i_in_ready(o_in_ready), .i_out_valid(o_out_valid),
      .i_first(o_first_channel_output), .i_second(o_second_channel_output), .i_stall(stall),
      .o_valid(i_in_valid), .o_first(i_first_sample), .o_second(i_second_sample), .o_ready(i_out_ready));
   always #20 i_core_clk = ~i_core_clk;
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Longest legal run is about 23k cycles
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 60000) begin
         fail_count++;
         print_verdict();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_core_clk);
      i_reg_wr    = 1'b1;
      i_reg_addr  = a;
      i_reg_wdata = d;
      @(negedge i_core_clk);
      i_reg_wr    = 1'b0;
      i_reg_wdata = ~d;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(negedge i_core_clk);
      i_reg_rd   = 1'b1;
      i_reg_addr = a;
      @(negedge i_core_clk);
      i_reg_rd   = 1'b0;
      `CHK("rdata", o_reg_rdata, e)
   endtask
   task automatic frame(input logic [23:0] a, input logic [23:0] b);
      int n;
      n = 0;
      pm.send(a, b);
      while (pm.got_q.size() == 0 && n < 64) begin
         @(negedge i_core_clk);
         n++;
      end
      g = 'x;
      if (pm.got_q.size() > 0) g = pm.got_q.pop_front();
   endtask
   // Alternating signs give a zero crossing on every frame after the first
   task automatic frames(input int k, input logic alt);
      for (int i = 0; i < k; i++) frame((alt && i[0]) ? NEG : S, (alt && i[0]) ? NEG : S);
   endtask
   task automatic lvl(input logic [7:0] a, input logic [7:0] b);
      wr(8'h03, a);
      wr(8'h04, b);
      frames(2, 1'b0);
   endtask
   task automatic t_reset;
      rd_chk(8'h02, 8'h49);
      rd_chk(8'h03, 8'h00);
      rd_chk(8'h04, 8'h00);
      frame(S, NEG);
      `CHK("unity", g, {S, NEG})
      wr(8'h03, 8'h8A);
      wr(8'h04, 8'h14);
      wr(8'h05, 8'hFF);
      rd_chk(8'h03, 8'h8A);
      rd_chk(8'h04, 8'h14);
      rd_chk(8'h05, 8'h00);
      $display("test reset and registers done");
   endtask
   task automatic t_immediate;
      wr(8'h02, 8'h09);
      lvl(8'h14, 8'h00);
      `CHK("minus20", g[47:24] > 24'h017400 && g[47:24] < 24'h01BC00, 1'b1)
      `CHK("b_unity", g[23:0], S)
      lvl(8'h5E, 8'h80);
      `CHK("code94", g[47:24] != 24'h000000, 1'b1)
      `CHK("silence_bit", g[23:0], 24'h000000)
      `CHK("one_silenced", o_both_silenced_indicator, 1'b0)
      lvl(8'h5F, 8'h80);
      `CHK("code95", g[47:24], 24'h000000)
      `CHK("both_silenced", o_both_silenced_indicator, 1'b1)
      wr(8'h02, 8'h89);
      lvl(8'h80, 8'h00);
      `CHK("link_silent", g, 48'h000000000000)
      lvl(8'h00, 8'h80);
      `CHK("link_unity", g, {S, S})
      `CHK("link_ind", o_both_silenced_indicator, 1'b0)
      $display("test immediate and link done");
   endtask
   task automatic t_ramp;
      wr(8'h02, 8'h09);
      lvl(8'h00, 8'h00);
      wr(8'h02, 8'h49);
      wr(8'h03, 8'h80);
      frames(2, 1'b0);
      `CHK("first_step", g[47:24] > 24'h0F8000 && g[47:24] < S, 1'b1)
      frames(78, 1'b0);
      `CHK("ten_db", g[47:24] > 24'h048000 && g[47:24] < 24'h05B000, 1'b1)
      frames(620, 1'b0);
      `CHK("near_end", g[47:24] != 24'h000000, 1'b1)
      frames(70, 1'b0);
      `CHK("ramp_end", g[47:24], 24'h000000)
      wr(8'h02, 8'h69);
      wr(8'h03, 8'h00);
      frames(40, 1'b0);
      `CHK("no_cross_wait", g[47:24], 24'h000000)
      frames(81, 1'b1);
      `CHK("cross_steps", g[47:24] != 24'h000000, 1'b1)
      $display("test ramp done");
   endtask
   task automatic t_zero;
      wr(8'h02, 8'h29);
      wr(8'h03, 8'h80);
      frames(505, 1'b0);
      `CHK("zc_pending", g[47:24] != 24'h000000, 1'b1)
      frames(15, 1'b0);
      `CHK("zc_timeout", g[47:24], 24'h000000)
      wr(8'h03, 8'h00);
      wr(8'h04, 8'h80);
      frame(NEG, S);
      frame(NEG, S);
      `CHK("zc_per_chan", g, {NEG, S})
      $display("test zero cross done");
   endtask
   task automatic t_buffer;
      wr(8'h02, 8'h09);
      lvl(8'h00, 8'h00);
      stall = 1'b1;
      for (int i = 1; i < 4; i++) pm.send(S + 24'(i), NEG + 24'(i));
      repeat (20) @(negedge i_core_clk);
      `CHK("full_refuses", o_in_ready, 1'b0)
      `CHK("full_valid", o_out_valid, 1'b1)
      stall = 1'b0;
      repeat (30) @(negedge i_core_clk);
      `CHK("count", pm.got_q.size(), 3)
      for (int i = 1; i < 4; i++) begin
         g = pm.got_q.pop_front();
         `CHK("order", g, {S + 24'(i), NEG + 24'(i)})
      end
      $display("test buffer done");
   endtask
   initial begin
      repeat (5) @(negedge i_core_clk);
      i_srst = 1'b0;
      t_reset();
      t_immediate();
      t_ramp();
      t_zero();
      t_buffer();
      print_verdict();
   end
endmodule

// >>> verilog/frame_if.sv
// Valid/ready carrier for one stereo frame between internal modules
`timescale 1ns/1ps
interface frame_if #(
   parameter int W = 48
);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// >>> verilog/gain_calc.sv
// Serial conversion of an attenuation level in eighth-dB units to a linear gain
`timescale 1ns/1ps
`include "vol_defines.svh"
module gain_calc (
   input  wire logic                  i_core_clk,
   input  wire logic                  i_srst,
   input  wire logic                  i_start,
   input  wire logic [`LEVEL_W-1:0]   i_level,
   output logic                       o_busy,
   output logic [`GAIN_W-1:0]         o_gain
);
   logic [3:0]            bit_idx;
   logic [`LEVEL_W-1:0]   level;
   logic [`GAIN_W-1:0]    acc;

   // Factor 10^(-2^k/160) per level bit, unsigned with 16 fraction bits
   function automatic logic [15:0] bit_factor(input logic [3:0] k);
      case (k)
         4'h0:    bit_factor = 16'hFC58;
         4'h1:    bit_factor = 16'hF8BD;
         4'h2:    bit_factor = 16'hF1AE;
         4'h3:    bit_factor = 16'hE429;
         4'h4:    bit_factor = 16'hCB59;
         4'h5:    bit_factor = 16'hA186;
         4'h6:    bit_factor = 16'h65EA;
         4'h7:    bit_factor = 16'h2893;
         4'h8:    bit_factor = 16'h066E;
         4'h9:    bit_factor = 16'h0029;
         default: bit_factor = 16'hFFFF;
      endcase
   endfunction

   // One multiply per level bit keeps area small at the cost of ten cycles
   wire [`GAIN_W+15:0] product  = acc * bit_factor(bit_idx);
   wire [`GAIN_W-1:0]  scaled   = product[`GAIN_FRAC_BITS +: `GAIN_W];
   wire [`GAIN_W-1:0]  next_acc = level[bit_idx] ? scaled : acc;
   wire                last     = (bit_idx == `GAIN_STEPS - 4'h1);
   wire                silent   = (level >= `SILENT_LEVEL);

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         o_busy  <= 1'b0;
         bit_idx <= 4'h0;
         level   <= `LEVEL_ZERO;
         acc     <= `UNITY_GAIN;
         o_gain  <= `UNITY_GAIN;
      end else if (i_start) begin
         o_busy  <= 1'b1;
         bit_idx <= 4'h0;
         level   <= i_level;
         acc     <= `UNITY_GAIN;
      end else if (o_busy) begin
         acc     <= next_acc;
         bit_idx <= bit_idx + 4'h1;
         o_busy  <= ~last;
         if (last) begin
            o_gain <= silent ? `ZERO_GAIN : next_acc;
         end
      end
   end
endmodule

// >>> verilog/pair_buffer.sv
// Small FIFO holding processed frames while the receiver stalls
`timescale 1ns/1ps
module pair_buffer #(
   parameter int W     = 48,
   parameter int DEPTH = 2
) (
   input  wire logic i_core_clk,
   input  wire logic i_srst,
   frame_if.snk      fill,
   frame_if.src      drain
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0]   count;
   wire           push = fill.valid & fill.ready;
   wire           pop  = drain.valid & drain.ready;
   wire [PW-1:0]  wr_next = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
   wire [PW-1:0]  rd_next = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
   wire [PW:0]    next_count = count + (PW+1)'(push) - (PW+1)'(pop);

   // Full and empty come straight from the count, so back-pressure is exact
   assign fill.ready  = (count != (PW+1)'(DEPTH));
   assign drain.valid = (count != '0);
   assign drain.data  = mem[rd_ptr];

   always_ff @(posedge i_core_clk) begin
      if (push) begin
         mem[wr_ptr] <= fill.data;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= push ? wr_next : wr_ptr;
         rd_ptr <= pop ? rd_next : rd_ptr;
         count  <= next_count;
      end
   end
endmodule

// >>> verilog/stereo_digital_volume_mute.sv
// Stereo digital attenuation and silencing stage with transition control
`timescale 1ns/1ps
`include "vol_defines.svh"
module stereo_digital_volume_mute #(
   parameter int DATA_W = 24,
   parameter int DEPTH  = 2
) (
   input  wire logic              i_core_clk,
   input  wire logic              i_srst,
   input  wire logic              i_reg_wr,
   input  wire logic              i_reg_rd,
   input  wire logic [7:0]        i_reg_addr,
   input  wire logic [7:0]        i_reg_wdata,
   output logic [7:0]             o_reg_rdata,
   input  wire logic              i_in_valid,
   output logic                   o_in_ready,
   input  wire logic [DATA_W-1:0] i_first_sample,
   input  wire logic [DATA_W-1:0] i_second_sample,
   output logic                   o_out_valid,
   input  wire logic              i_out_ready,
   output logic [DATA_W-1:0]      o_first_channel_output,
   output logic [DATA_W-1:0]      o_second_channel_output,
   output logic                   o_both_silenced_indicator
);
   localparam int FW = 2 * DATA_W;

   logic [7:0]             xfer_ctrl;
   logic [7:0]             level_reg [2];
   vol_pkg::phase_t        phase;
   logic [DATA_W-1:0]      smp_hold [2];
   logic [`LEVEL_W-1:0]    applied [2];
   logic [`LEVEL_W-1:0]    zc_wait [2];
   logic                   prev_sign [2];
   logic [`GAIN_W-1:0]     gain [2];
   logic                   gain_busy [2];
   logic [DATA_W-1:0]      scaled [2];
   logic [FW-1:0]          frame_out;
   logic                   all_silent [2];

   frame_if #(.W(FW)) to_buf ();
   frame_if #(.W(FW)) from_buf ();

   // Register decode
   wire hit_ctrl = (i_reg_addr == `ADDR_XFER_CTRL);
   wire hit_a    = (i_reg_addr == `ADDR_LEVEL_A);
   wire hit_b    = (i_reg_addr == `ADDR_LEVEL_B);
   wire [7:0] read_mux = hit_ctrl ? xfer_ctrl :
                         hit_a    ? level_reg[0] :
                         hit_b    ? level_reg[1] : `READ_UNMAPPED;

   wire                 link  = xfer_ctrl[`XFER_LINK_BIT];
   wire vol_pkg::style_t style =
      vol_pkg::style_t'(xfer_ctrl[`XFER_STYLE_HI:`XFER_STYLE_LO]);

   // Frame handshake
   wire take       = i_in_valid & o_in_ready;
   wire start_gain = (phase == vol_pkg::PH_START);
   wire gain_done  = ~gain_busy[0] & ~gain_busy[1] & (phase == vol_pkg::PH_GAIN);
   wire push_done  = to_buf.valid & to_buf.ready;
   wire [DATA_W-1:0] in_smp [2];
   assign in_smp[0] = i_first_sample;
   assign in_smp[1] = i_second_sample;

   assign o_in_ready = (phase == vol_pkg::PH_IDLE);

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         xfer_ctrl    <= `XFER_CTRL_RESET;
         level_reg[0] <= `LEVEL_RESET;
         level_reg[1] <= `LEVEL_RESET;
         o_reg_rdata  <= `READ_UNMAPPED;
      end else begin
         if (i_reg_wr && hit_ctrl) begin
            xfer_ctrl <= i_reg_wdata;
         end
         if (i_reg_wr && hit_a) begin
            level_reg[0] <= i_reg_wdata;
         end
         if (i_reg_wr && hit_b) begin
            level_reg[1] <= i_reg_wdata;
         end
         if (i_reg_rd) begin
            o_reg_rdata <= read_mux;
         end
      end
   end

   // Frame sequencing: one frame in flight keeps levels and samples aligned
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         phase <= vol_pkg::PH_IDLE;
      end else begin
         case (phase)
            vol_pkg::PH_IDLE: begin
               if (take) begin
                  phase <= vol_pkg::PH_START;
               end
            end
            vol_pkg::PH_START: begin
               phase <= vol_pkg::PH_GAIN;
            end
            vol_pkg::PH_GAIN: begin
               if (gain_done) begin
                  phase <= vol_pkg::PH_PUSH;
               end
            end
            vol_pkg::PH_PUSH: begin
               if (push_done) begin
                  phase <= vol_pkg::PH_IDLE;
               end
            end
            default: begin
               phase <= vol_pkg::PH_IDLE;
            end
         endcase
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         // Second channel follows the first when linked
         wire [7:0] req = (ch == 1 && link) ? level_reg[0] : level_reg[ch];
         wire [6:0] code = req[`LEVEL_CODE_HI:`LEVEL_CODE_LO];
         wire req_silent = req[`LEVEL_SILENCE_BIT] | (code >= `SILENT_CODE_MIN);
         // Code counts whole dB, applied level counts eighths
         wire [`LEVEL_W-1:0] target = req_silent ? `SILENT_LEVEL :
                                      {code, `EIGHTHS_PAD};
         wire new_sign  = in_smp[ch][DATA_W-1];
         wire crossing  = (in_smp[ch] == '0) | (new_sign != prev_sign[ch]);
         wire timed_out = (zc_wait[ch] >= `ZC_TIMEOUT_FRAMES - `ZC_COUNT_STEP);
         wire step_ok   = crossing | timed_out;
         wire at_target = (applied[ch] == target);
         wire [`LEVEL_W-1:0] toward = (applied[ch] < target) ?
                                      applied[ch] + `LEVEL_STEP :
                                      applied[ch] - `LEVEL_STEP;
         wire [`LEVEL_W-1:0] next_applied =
            (style == vol_pkg::STYLE_IMMEDIATE)  ? target :
            (style == vol_pkg::STYLE_ZERO_CROSS) ? (step_ok ? target : applied[ch]) :
            (style == vol_pkg::STYLE_SOFT_RAMP)  ? toward :
                                                   (step_ok ? toward : applied[ch]);
         wire zc_mode = (style == vol_pkg::STYLE_ZERO_CROSS) |
                        (style == vol_pkg::STYLE_SOFT_ZERO);
         wire moved   = (next_applied != applied[ch]);
         wire [`LEVEL_W-1:0] next_wait = (at_target | moved | ~zc_mode) ? `ZC_COUNT_ZERO :
                                         zc_wait[ch] + `ZC_COUNT_STEP;
         wire signed [DATA_W+`GAIN_W:0] product =
            $signed(smp_hold[ch]) * $signed({1'b0, gain[ch]});
         assign all_silent[ch] = req_silent & (applied[ch] == `SILENT_LEVEL);

         // Levels move once per frame, so a frame counts as one left/right period
         always_ff @(posedge i_core_clk) begin
            if (i_srst) begin
               applied[ch]   <= `LEVEL_ZERO;
               zc_wait[ch]   <= `ZC_COUNT_ZERO;
               prev_sign[ch] <= 1'b0;
               smp_hold[ch]  <= '0;
            end else if (take) begin
               applied[ch]   <= at_target ? applied[ch] : next_applied;
               zc_wait[ch]   <= next_wait;
               prev_sign[ch] <= new_sign;
               smp_hold[ch]  <= in_smp[ch];
            end
         end

         gain_calc u_gain (
            .i_core_clk (i_core_clk),
            .i_srst     (i_srst),
            .i_start    (start_gain),
            .i_level    (applied[ch]),
            .o_busy     (gain_busy[ch]),
            .o_gain     (gain[ch])
         );

         // Zero gain at the silent level leaves midscale, not a dropped output
         assign scaled[ch] = product[`GAIN_FRAC_BITS +: DATA_W];
      end
   endgenerate

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         frame_out                 <= '0;
         o_both_silenced_indicator <= 1'b0;
      end else begin
         if (gain_done) begin
            frame_out <= {scaled[0], scaled[1]};
         end
         o_both_silenced_indicator <= all_silent[0] & all_silent[1];
      end
   end

   assign to_buf.valid = (phase == vol_pkg::PH_PUSH);
   assign to_buf.data  = frame_out;

   pair_buffer #(
      .W     (FW),
      .DEPTH (DEPTH)
   ) u_buf (
      .i_core_clk (i_core_clk),
      .i_srst     (i_srst),
      .fill       (to_buf.snk),
      .drain      (from_buf.src)
   );

   assign from_buf.ready          = i_out_ready;
   assign o_out_valid             = from_buf.valid;
   assign o_first_channel_output  = from_buf.data[FW-1:DATA_W];
   assign o_second_channel_output = from_buf.data[DATA_W-1:0];
endmodule

// >>> verilog/vol_defines.svh
// Register map, field positions, reset values and counts of the volume stage
`ifndef VOL_DEFINES_SVH
`define VOL_DEFINES_SVH
`define ADDR_XFER_CTRL     8'h02
`define ADDR_LEVEL_A       8'h03
`define ADDR_LEVEL_B       8'h04
`define XFER_CTRL_RESET    8'h49
`define LEVEL_RESET        8'h00
`define READ_UNMAPPED      8'h00
`define XFER_LINK_BIT      7
`define XFER_STYLE_HI      6
`define XFER_STYLE_LO      5
`define LEVEL_SILENCE_BIT  7
`define LEVEL_CODE_HI      6
`define LEVEL_CODE_LO      0
`define SILENT_CODE_MIN    7'h5F
`define LEVEL_W            10
`define EIGHTHS_PAD        3'h0
`define SILENT_LEVEL       10'h2F8
`define LEVEL_ZERO         10'h000
`define LEVEL_STEP         10'h001
`define ZC_TIMEOUT_FRAMES  10'h200
`define ZC_COUNT_ZERO      10'h000
`define ZC_COUNT_STEP      10'h001
`define GAIN_W             17
`define GAIN_FRAC_BITS     16
`define UNITY_GAIN         17'h10000
`define ZERO_GAIN          17'h00000
`define GAIN_STEPS         4'hA
`endif

// >>> verilog/vol_pkg.sv
// Types shared by the volume stage modules
package vol_pkg;
   typedef enum logic [1:0] {
      STYLE_IMMEDIATE,
      STYLE_ZERO_CROSS,
      STYLE_SOFT_RAMP,
      STYLE_SOFT_ZERO
   } style_t;
   typedef enum {
      PH_IDLE,
      PH_START,
      PH_GAIN,
      PH_PUSH
   } phase_t;
endpackage
